// ### tbc_cmd_assertions.sv
/* Checker for the command block. Assumes a bind from the bench. */
`timescale 1ns/1ps
`include "tbc_defines.vh"
module tbc_cmd_assertions (
  // Clock, reset, status
  input wire mclk, input wire rst, input wire respValid, input wire restartReq, input wire moduleReady,
  // Image words
  input wire [15:0] outSeq, input wire [15:0] outBlockId, input wire [15:0] inSeq, input wire [15:0] inBlockId,
  input wire [15:0] inYear, input wire [15:0] inMonth, input wire [15:0] inDay, input wire [15:0] inHour,
  input wire [15:0] inMinute, input wire [15:0] inSecond, input wire [15:0] inMilli
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire isRd = inBlockId == `TBC_ID_READ_TIME;
  wire isBoot = inBlockId == `TBC_ID_WARM || inBlockId == `TBC_ID_COLD;
  wire known = outBlockId == `TBC_ID_READ_TIME || outBlockId == `TBC_ID_SET_TIME ||
    outBlockId == `TBC_ID_WARM || outBlockId == `TBC_ID_COLD;
  a_seq_plus_one: assert property (respValid |-> inSeq == $past(outSeq) + 16'h0001) else $error("bad seq");
  a_needs_change: assert property (respValid |-> $past(outSeq) != $past(outSeq, 2)) else $error("no change");
  a_id_echo: assert property (respValid |-> inBlockId == $past(outBlockId)) else $error("bad id");
  a_unknown_quiet: assert property (moduleReady && outSeq != $past(outSeq) && !known |=> !respValid)
    else $error("unknown answered");
  a_set_no_time: assert property (respValid && inBlockId == `TBC_ID_SET_TIME |-> inYear == 0 && inMilli == 0)
    else $error("set has time");
  a_date_range: assert property (respValid && isRd |-> inMonth inside {[`TBC_MONTH_MIN:`TBC_MONTH_MAX]} &&
    inDay inside {[`TBC_DAY_MIN:`TBC_DAY_MAX]}) else $error("date range");
  a_time_range: assert property (respValid && isRd |-> inHour <= `TBC_HOUR_MAX && inMinute <= `TBC_MIN_MAX &&
    inSecond <= `TBC_SEC_MAX && inMilli <= `TBC_MS_MAX) else $error("time range");
  a_boot_restart: assert property (respValid && isBoot |-> restartReq && !moduleReady ##1 restartReq[*4])
    else $error("no restart");
  a_restart_stops: assert property (restartReq |-> !moduleReady ##1 !respValid) else $error("busy in restart");
  c_read: cover property (respValid && isRd);
  c_set: cover property (respValid && inBlockId == `TBC_ID_SET_TIME);
  c_boot: cover property ($rose(restartReq));
endmodule // tbc_cmd_assertions

// ### tbc_cmd_block.v
/*
  Command-control block interpreter with its own date and time clock.
  Assumes the output image words come from logic on mclk, stable per scan.
*/
`timescale 1ns/1ps
`include "tbc_defines.vh"
module tbc_cmd_block #(
  parameter MS_CYCLES = `TBC_MS_NS / `TBC_CLK_NS,
  parameter RESTART_CYCLES = `TBC_RESTART_CYCLES
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Output image from controller
  input wire [15:0] outSeq,
  input wire [15:0] outBlockId,
  input wire [15:0] outYear,
  input wire [15:0] outMonth,
  input wire [15:0] outDay,
  input wire [15:0] outHour,
  input wire [15:0] outMinute,
  input wire [15:0] outSecond,
  input wire [15:0] outMilli,
  // Input image to controller
  output reg [15:0] inSeq,
  output reg [15:0] inBlockId,
  output reg [15:0] inYear,
  output reg [15:0] inMonth,
  output reg [15:0] inDay,
  output reg [15:0] inHour,
  output reg [15:0] inMinute,
  output reg [15:0] inSecond,
  output reg [15:0] inMilli,
  output wire respValid,
  // Restart control
  output wire restartReq,
  output wire moduleReady
);
  localparam ST_INIT = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_RESTART = 3'b100;

  function [15:0] inc16;
    input [15:0] v;
    begin
      inc16 = v + 16'h0001;
    end
  endfunction

  function inRange;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      inRange = (v >= lo) && (v <= hi);
    end
  endfunction

  // Roll one calendar field: back to its first value after its last
  function [15:0] nextField;
    input [15:0] v;
    input [15:0] last;
    input [15:0] first;
    begin
      nextField = (v == last) ? first : inc16(v);
    end
  endfunction

  // Either restart identifier
  function isBootId;
    input [15:0] id;
    begin
      isBootId = (id == `TBC_ID_WARM) || (id == `TBC_ID_COLD);
    end
  endfunction

  // Restart end point, compared on the counter's own width
  localparam [31:0] RESTART_LAST = RESTART_CYCLES - 1;

  wire msTick;
  reg [2:0] state_r;
  reg [15:0] lastSeq_r;
  reg [7:0] restartCnt_r;
  reg respValid_r;
  // Running date and time
  reg [15:0] year_r;
  reg [15:0] month_r;
  reg [15:0] day_r;
  reg [15:0] hour_r;
  reg [15:0] minute_r;
  reg [15:0] second_r;
  reg [15:0] milli_r;

  tbc_ms_tick #(.DIV(MS_CYCLES)) uTick (
    .mclk(mclk),
    .rst(rst),
    .tick(msTick)
  );

  wire seqChanged = (state_r == ST_RUN) && (outSeq != lastSeq_r); // [R01]
  wire isRead = (outBlockId == `TBC_ID_READ_TIME);
  wire isSet = (outBlockId == `TBC_ID_SET_TIME);
  wire isBoot = isBootId(outBlockId); // [R09]
  wire setOk = inRange(outMonth, `TBC_MONTH_MIN, `TBC_MONTH_MAX) &&
    inRange(outDay, `TBC_DAY_MIN, `TBC_DAY_MAX) &&
    inRange(outHour, 16'h0000, `TBC_HOUR_MAX) &&
    inRange(outMinute, 16'h0000, `TBC_MIN_MAX) &&
    inRange(outSecond, 16'h0000, `TBC_SEC_MAX) &&
    inRange(outMilli, 16'h0000, `TBC_MS_MAX); // [R05] [R06]

  assign respValid = respValid_r;
  assign restartReq = (state_r == ST_RESTART); // [R10]
  // Both decode one state register, so they are never high together
  assign moduleReady = (state_r == ST_RUN);

  // Free-running calendar, 31 days per month
  // A set wins over a tick in the same cycle; that tick is dropped
  wire msWrap = (milli_r == `TBC_MS_MAX);
  wire secWrap = msWrap && (second_r == `TBC_SEC_MAX);
  wire minWrap = secWrap && (minute_r == `TBC_MIN_MAX);
  wire hourWrap = minWrap && (hour_r == `TBC_HOUR_MAX);
  wire dayWrap = hourWrap && (day_r == `TBC_DAY_MAX);
  wire monWrap = dayWrap && (month_r == `TBC_MONTH_MAX);

  always @(posedge mclk) begin
    if (rst) begin
      year_r <= `TBC_RESET_YEAR;
      month_r <= `TBC_MONTH_MIN;
      day_r <= `TBC_DAY_MIN;
      hour_r <= 16'h0000;
      minute_r <= 16'h0000;
      second_r <= 16'h0000;
      milli_r <= 16'h0000;
    end else if (seqChanged && isSet && setOk) begin
      year_r <= outYear; // [R07]
      month_r <= outMonth;
      day_r <= outDay;
      hour_r <= outHour;
      minute_r <= outMinute;
      second_r <= outSecond;
      milli_r <= outMilli;
    end else if (msTick) begin
      milli_r <= nextField(milli_r, `TBC_MS_MAX, 16'h0000); // [R06]
      if (msWrap) second_r <= nextField(second_r, `TBC_SEC_MAX, 16'h0000);
      if (secWrap) minute_r <= nextField(minute_r, `TBC_MIN_MAX, 16'h0000);
      if (minWrap) hour_r <= nextField(hour_r, `TBC_HOUR_MAX, 16'h0000);
      if (hourWrap) day_r <= nextField(day_r, `TBC_DAY_MAX, `TBC_DAY_MIN); // [R05]
      if (dayWrap) month_r <= nextField(month_r, `TBC_MONTH_MAX, `TBC_MONTH_MIN);
      if (monWrap) year_r <= inc16(year_r);
    end
  end

  // Sequencer and response image
  always @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_INIT;
      lastSeq_r <= 16'h0000;
      restartCnt_r <= 8'h00;
      respValid_r <= 1'b0;
      inSeq <= 16'h0000;
      inBlockId <= 16'h0000;
      inYear <= 16'h0000;
      inMonth <= 16'h0000;
      inDay <= 16'h0000;
      inHour <= 16'h0000;
      inMinute <= 16'h0000;
      inSecond <= 16'h0000;
      inMilli <= 16'h0000;
    end else begin
      respValid_r <= 1'b0;
      case (state_r)
        ST_INIT: begin
          // Baseline, so a stale sequence value is not taken as a request
          lastSeq_r <= outSeq;
          state_r <= ST_RUN;
        end
        ST_RUN: begin
          // One request per change of the sequence word
          if (seqChanged) begin
            lastSeq_r <= outSeq; // [R01]
            if (isRead) begin
              inSeq <= inc16(outSeq); // [R02]
              inBlockId <= `TBC_ID_READ_TIME; // [R03]
              inYear <= year_r; // [R04]
              inMonth <= month_r;
              inDay <= day_r;
              inHour <= hour_r;
              inMinute <= minute_r;
              inSecond <= second_r;
              inMilli <= milli_r;
              respValid_r <= 1'b1;
            end else if (isSet && setOk) begin
              inSeq <= inc16(outSeq); // [R02]
              inBlockId <= `TBC_ID_SET_TIME; // [R08]
              inYear <= 16'h0000;
              inMonth <= 16'h0000;
              inDay <= 16'h0000;
              inHour <= 16'h0000;
              inMinute <= 16'h0000;
              inSecond <= 16'h0000;
              inMilli <= 16'h0000;
              respValid_r <= 1'b1;
            end else if (isBoot) begin
              // Answer as the restart starts so the controller sees the request complete
              inSeq <= inc16(outSeq); // [R02]
              inBlockId <= outBlockId;
              restartCnt_r <= 8'h00;
              respValid_r <= 1'b1;
              state_r <= ST_RESTART; // [R09]
            end
            // Others: no answer [R15]
          end
        end
        ST_RESTART: begin
          // Sequence changes here are dropped; INIT takes a new baseline
          restartCnt_r <= restartCnt_r + 8'h01;
          if (restartCnt_r == RESTART_LAST[7:0])
            state_r <= ST_INIT; // [R10]
        end
        default: state_r <= ST_INIT;
      endcase
    end
  end
endmodule // tbc_cmd_block

// ### tbc_cmd_block_tb.sv
/* Bench for the command block. Assumes the controller model drives the image. */
`timescale 1ns/1ps
`include "tbc_defines.vh"
module tbc_cmd_block_tb;
  logic mclk, rst, got;
  wire [15:0] outSeq, outBlockId, outYear, outMonth, outDay, outHour, outMinute, outSecond, outMilli;
  wire [15:0] inSeq, inBlockId, inYear, inMonth, inDay, inHour, inMinute, inSecond, inMilli;
  wire respValid, restartReq, moduleReady;
  int errors, nCompared;
  tbc_ctrl_model tbc_ctrl_model_i (.mclk, .outSeq, .outBlockId, .outYear, .outMonth, .outDay, .outHour,
    .outMinute, .outSecond, .outMilli);
  tbc_cmd_block #(.MS_CYCLES(25), .RESTART_CYCLES(16)) tbc_cmd_block_i (.mclk, .rst, .outSeq, .outBlockId,
    .outYear, .outMonth, .outDay, .outHour, .outMinute, .outSecond, .outMilli, .inSeq, .inBlockId, .inYear,
    .inMonth, .inDay, .inHour, .inMinute, .inSecond, .inMilli, .respValid, .restartReq, .moduleReady);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic req(input logic [15:0] id, input logic [111:0] t, input bit bump);
    tbc_ctrl_model_i.send(id, t, bump);
    got = 0;
    for (int i = 0; i < 8 && !got; i++) begin
      if (respValid === 1'b1) got = 1;
      else begin @(posedge mclk); #1; end
    end
  endtask
  task automatic tRead(input logic [15:0] y, input logic [15:0] mo, input logic [15:0] d, input logic [15:0] h,
    input logic [15:0] mi, input logic [15:0] s, input logic [15:0] msLo);
    req(`TBC_ID_READ_TIME, '0, 1);
    chk("resp", 16'h0001, {15'h0000, got});
    chk("seq", outSeq + 16'h0001, inSeq);
    chk("id", `TBC_ID_READ_TIME, inBlockId);
    chk("year", y, inYear);
    chk("month", mo, inMonth);
    chk("day", d, inDay);
    chk("hour", h, inHour);
    chk("minute", mi, inMinute);
    chk("second", s, inSecond);
    chk("milli", 16'h0001, {15'h0000, (inMilli >= msLo) && (inMilli <= msLo + 16'h0009)});
  endtask
  task automatic tSet();
    req(`TBC_ID_SET_TIME, {16'h07e8, 16'h000c, 16'h001f, 16'h0017, 16'h003b, 16'h003b, 16'h03de}, 1);
    chk("resp", 16'h0001, {15'h0000, got});
    chk("id", `TBC_ID_SET_TIME, inBlockId);
    chk("year", 16'h0000, inYear);
    chk("milli", 16'h0000, inMilli);
    chk("seq", outSeq + 16'h0001, inSeq);
    tRead(16'h07e8, 16'h000c, 16'h001f, 16'h0017, 16'h003b, 16'h003b, 16'h03de);
    repeat (300) @(posedge mclk);
    #1;
    tRead(16'h07e9, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    $display("test set done");
  endtask
  task automatic tRefuse();
    logic [15:0] ids [3];
    ids = '{`TBC_ID_SET_TIME, 16'h04d2, `TBC_ID_READ_TIME};
    for (int i = 0; i < 3; i++) begin
      req(ids[i], {16'h07e8, 16'h000d, 16'h0001, 64'h0}, i != 2);
      chk("quiet", 16'h0000, {15'h0000, got});
    end
    $display("test refuse done");
  endtask
  task automatic tBoot();
    logic [15:0] ids [2];
    ids = '{`TBC_ID_WARM, `TBC_ID_COLD};
    for (int i = 0; i < 2; i++) begin
      req(ids[i], '0, 1);
      chk("id", ids[i], inBlockId);
      chk("seq", outSeq + 16'h0001, inSeq);
      chk("restart", 16'h0001, {15'h0000, restartReq});
      chk("ready", 16'h0000, {15'h0000, moduleReady});
      for (int k = 0; k < 40 && moduleReady !== 1'b1; k++) begin @(posedge mclk); #1; end
      req(`TBC_ID_READ_TIME, '0, 1);
      chk("after", 16'h0001, {15'h0000, got});
    end
    $display("test boot done");
  endtask
  task automatic tReset();
    rst = 1;
    repeat (2) @(posedge mclk);
    #1;
    chk("rst_seq", 16'h0000, inSeq);
    chk("rst_ready", 16'h0000, {15'h0000, moduleReady});
    rst = 0;
    repeat (3) @(posedge mclk);
    #1;
    tRead(`TBC_RESET_YEAR, `TBC_MONTH_MIN, `TBC_DAY_MIN, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    $display("test reset done");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    rst = 1;
    repeat (4) @(posedge mclk);
    #1 rst = 0;
    repeat (3) @(posedge mclk);
    tRead(16'h07d0, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    $display("test read done");
    tSet();
    tRefuse();
    tBoot();
    tReset();
    print_verdict();
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule // tbc_cmd_block_tb
bind tbc_cmd_block tbc_cmd_assertions tbc_cmd_assertions_i (.mclk, .rst, .respValid, .restartReq, .moduleReady,
  .outSeq, .outBlockId, .inSeq, .inBlockId, .inYear, .inMonth, .inDay, .inHour, .inMinute, .inSecond, .inMilli);

// ### tbc_ctrl_model.sv
/* Controller model for the output image. Assumes the bench calls send. */
`timescale 1ns/1ps
module tbc_ctrl_model (
  // Clock
  input wire mclk,
  // Output image
  output logic [15:0] outSeq, output logic [15:0] outBlockId,
  output wire [15:0] outYear, output wire [15:0] outMonth, output wire [15:0] outDay, output wire [15:0] outHour,
  output wire [15:0] outMinute, output wire [15:0] outSecond, output wire [15:0] outMilli
);
  logic [111:0] tw;
  assign {outYear, outMonth, outDay, outHour, outMinute, outSecond, outMilli} = tw;
  initial begin
    outSeq = 16'h0000;
    outBlockId = 16'h0000;
    tw = '0;
  end
  task automatic send(input logic [15:0] id, input logic [111:0] t, input bit bump);
    @(posedge mclk); #1;
    outBlockId = id;
    tw = t;
    @(posedge mclk); #1;
    if (bump) outSeq = outSeq + 16'h0001;
    @(posedge mclk); #1;
    outBlockId = 16'h0000;
  endtask
endmodule // tbc_ctrl_model

// ### tbc_defines.vh
/*
  Constants for the time and boot command-block interpreter.
  Assumes the block image words are 16 bits wide and are held stable by the controller for a scan.
*/
// Function
// [R01] Start a request only when output word 0 differs from the last seen value.
// [R02] Response word 0 is the received sequence value plus one.
// [R03] Read-time request answers identifier 9970 in word 1 and date and time after.
// [R04] Read-time answer: year word 2, month to seconds, milliseconds in word 8.
// [R05] Month lies within 1 to 12, day within 1 to 31.
// [R06] Hour 0 to 23, minute and seconds 0 to 59, milliseconds 0 to 999.
// [R07] Identifier 9971 loads the clock from the supplied date and time words.
// [R08] Set-time answer holds sequence plus one and 9971, no time fields.
// [R09] Identifier 9998 warm restarts, 9999 cold restarts the module.
// [R10] Both restarts act alike: stop, reinitialise, reload init-only configuration; code only pauses RESTART_CYCLES, date and time kept.
// [R11] Controller presents a new sequence and identifier for one scan only.
// [R12] Controller writes identifier first, then changes sequence; identifier alone requests nothing.
// [R13] Controller sees completion on matching identifier and sequence plus one.
// [R14] Controller writes sequence in word 0 and 9970 in word 1 to read time.
// [R15] Unknown identifiers are ignored and get no response block.
`ifndef TBC_DEFINES_VH
`define TBC_DEFINES_VH
`define TBC_ID_READ_TIME 16'h26f2
`define TBC_ID_SET_TIME 16'h26f3
`define TBC_ID_WARM 16'h270e
`define TBC_ID_COLD 16'h270f
`define TBC_MONTH_MIN 16'h0001
`define TBC_MONTH_MAX 16'h000c
`define TBC_DAY_MIN 16'h0001
`define TBC_DAY_MAX 16'h001f
`define TBC_HOUR_MAX 16'h0017
`define TBC_MIN_MAX 16'h003b
`define TBC_SEC_MAX 16'h003b
`define TBC_MS_MAX 16'h03e7
`define TBC_RESET_YEAR 16'h07d0
`define TBC_CLK_HZ 25000000
`define TBC_MS_NS 1000000
`define TBC_CLK_NS 40
`define TBC_RESTART_CYCLES 16
`endif

// ### tbc_ms_tick.v
/*
  Millisecond enable divider.
  Assumes a single clock; emits a one-cycle pulse every DIV cycles.
*/
`timescale 1ns/1ps
module tbc_ms_tick #(
  parameter DIV = 25000
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Enable out
  output reg tick
);
  reg [31:0] count_r;
  always @(posedge mclk) begin
    if (rst) begin
      count_r <= 32'h0;
      tick <= 1'b0;
    end else if (count_r == DIV - 1) begin
      count_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      count_r <= count_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // tbc_ms_tick
